/* File: design/cci_pkg.sv */
package cci_pkg;

  // ****************************************************************
  // Address map.
  // ****************************************************************
  localparam logic [31:0] CCI_BASE_ADDR  = 32'hF0F00000;
  localparam logic [19:0] CCI_BASE_PAGE  = 20'hF0F00;
  localparam logic [11:0] CCI_OFS_INIT   = 12'h000;
  localparam logic [11:0] CCI_OFS_FMT    = 12'h100;
  localparam logic [11:0] CCI_OFS_F0M    = 12'h180;
  localparam logic [11:0] CCI_OFS_F1M    = 12'h184;
  localparam logic [11:0] CCI_OFS_F2M    = 12'h188;
  localparam logic [11:0] CCI_OFS_RSV0   = 12'h18C;
  localparam logic [11:0] CCI_OFS_RSV1   = 12'h190;
  localparam logic [11:0] CCI_OFS_RSV2   = 12'h194;
  localparam logic [11:0] CCI_OFS_F6M    = 12'h198;
  localparam logic [11:0] CCI_OFS_F7M    = 12'h19C;
  localparam logic [11:0] CCI_OFS_F0R0   = 12'h200;
  localparam logic [11:0] CCI_OFS_F0R1   = 12'h204;
  localparam logic [11:0] CCI_OFS_F0R2   = 12'h208;
  localparam logic [11:0] CCI_OFS_F0R3   = 12'h20C;
  localparam logic [11:0] CCI_OFS_F0R4   = 12'h210;

  // ****************************************************************
  // Field layout. Flag bit n sits at word position 31 - n.
  // ****************************************************************
  localparam int          CCI_WORD_MSB   = 31;
  localparam int          CCI_FLAG_W     = 8;
  localparam int          CCI_RATE_REGS  = 5;
  localparam int          CCI_INIT_POS   = 31;
  localparam logic [7:0]  CCI_MASK_FMT   = 8'hC7;
  localparam logic [7:0]  CCI_MASK_F0M   = 8'h7F;
  localparam logic [7:0]  CCI_MASK_FULL  = 8'hFF;
  localparam logic [7:0]  CCI_MASK_F0R0  = 8'hFC;
  localparam logic [7:0]  CCI_MASK_NONE  = 8'h00;
  localparam logic [31:0] CCI_ZERO_WORD  = 32'h00000000;
  localparam logic [7:0]  CCI_FLAGS_RST  = 8'h00;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    CCI_RSP_COMPLETE = 2'b00,
    CCI_RSP_ADDR_ERR = 2'b01,
    CCI_RSP_TYPE_ERR = 2'b10
  } cci_rsp_e;

  typedef enum logic [1:0] {
    CCI_INIT_IDLE  = 2'b00,
    CCI_INIT_START = 2'b01,
    CCI_INIT_BUSY  = 2'b10
  } cci_init_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cci_req_s;

  typedef struct packed {
    logic        valid;
    cci_rsp_e    code;
    logic [31:0] rdata;
  } cci_rsp_s;

  typedef struct packed {
    logic [7:0]      formats;
    logic [7:0]      f0_modes;
    logic [7:0]      f1_modes;
    logic [7:0]      f2_modes;
    logic [7:0]      f7_modes;
    logic [4:0][7:0] f0_rates;
  } cci_caps_s;

endpackage : cci_pkg

/* File: design/cci_bitmap.sv */
module cci_bitmap
  import cci_pkg::*;
(
  input  wire logic [7:0]  flags,
  input  wire logic [7:0]  mask,
  output logic      [31:0] word
);

  // ****************************************************************
  // Flag n lands on word position 31 - n; reserved flags read zero.
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < CCI_FLAG_W; i++) begin : g_bit
      assign word[CCI_WORD_MSB - i] = flags[i] & mask[i];
    end
  endgenerate

  assign word[CCI_WORD_MSB - CCI_FLAG_W:0] = '0;

endmodule : cci_bitmap

/* File: design/cci_regs.sv */
module cci_regs
  import cci_pkg::*;
(
  input  wire logic      CLOCK,
  input  wire logic      RST_N,
  input  wire cci_req_s  REQ,
  input  wire cci_caps_s CAPS,
  input  wire logic      INIT_DONE,
  output cci_rsp_s       RSP,
  output logic           INIT_START,
  output logic           INIT_BUSY
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  cci_caps_s   caps_r;
  cci_rsp_s    rsp_r;
  cci_rsp_s    rsp_nxt;
  cci_init_e   init_state_r;
  cci_init_e   init_state_nxt;
  logic        init_start_r;
  logic        init_busy_r;
  logic [11:0] req_ofs;
  logic        in_page;
  logic        aligned;
  logic        hit;
  logic        writable;
  logic [7:0]  sel_flags;
  logic [7:0]  sel_mask;
  logic [31:0] sel_word;
  logic        init_wr;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  assign req_ofs = REQ.addr[11:0];
  assign in_page = (REQ.addr[31:12] == CCI_BASE_PAGE);
  assign aligned = (REQ.addr[1:0] == 2'h0);

  always_comb begin
    hit       = 1'b1;
    writable  = 1'b0;
    sel_flags = CCI_FLAGS_RST;
    sel_mask  = CCI_MASK_NONE;
    case (req_ofs)
      CCI_OFS_INIT: begin
        writable = 1'b1;
      end
      CCI_OFS_FMT: begin
        sel_flags = caps_r.formats;
        sel_mask  = CCI_MASK_FMT;
      end
      CCI_OFS_F0M: begin
        sel_flags = caps_r.f0_modes;
        sel_mask  = CCI_MASK_F0M;
      end
      CCI_OFS_F1M: begin
        sel_flags = caps_r.f1_modes;
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_F2M: begin
        sel_flags = caps_r.f2_modes;
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_RSV0, CCI_OFS_RSV1, CCI_OFS_RSV2, CCI_OFS_F6M: begin
        sel_mask = CCI_MASK_NONE;
      end
      CCI_OFS_F7M: begin
        sel_flags = caps_r.f7_modes;
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_F0R0: begin
        sel_flags = caps_r.f0_rates[0];
        sel_mask  = CCI_MASK_F0R0;
      end
      CCI_OFS_F0R1: begin
        sel_flags = caps_r.f0_rates[1];
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_F0R2: begin
        sel_flags = caps_r.f0_rates[2];
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_F0R3: begin
        sel_flags = caps_r.f0_rates[3];
        sel_mask  = CCI_MASK_FULL;
      end
      CCI_OFS_F0R4: begin
        sel_flags = caps_r.f0_rates[4];
        sel_mask  = CCI_MASK_FULL;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Read word assembly.
  // ****************************************************************
  cci_bitmap u_bitmap (
    .flags (sel_flags),
    .mask  (sel_mask),
    .word  (sel_word)
  );

  // ****************************************************************
  // Capability shadow, loaded only from the camera core.
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      caps_r <= '0;
    end else begin
      caps_r <= CAPS;
    end
  end

  // ****************************************************************
  // Response generation.
  // ****************************************************************
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = REQ.valid;
    rsp_nxt.code  = CCI_RSP_COMPLETE;
    rsp_nxt.rdata = CCI_ZERO_WORD;
    if (REQ.valid) begin
      if (!in_page) begin
        rsp_nxt.code = CCI_RSP_ADDR_ERR;
      end else if (!aligned) begin
        rsp_nxt.code = CCI_RSP_TYPE_ERR;
      end else if (!hit) begin
        rsp_nxt.code = CCI_RSP_ADDR_ERR;
      end else if (!REQ.write && !writable) begin
        rsp_nxt.rdata = sel_word;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // ****************************************************************
  // Initialize command sequencer.
  // ****************************************************************
  assign init_wr = REQ.valid && REQ.write && in_page && aligned
                   && (req_ofs == CCI_OFS_INIT)
                   && REQ.wdata[CCI_INIT_POS];

  always_comb begin
    init_state_nxt = init_state_r;
    case (init_state_r)
      CCI_INIT_IDLE: begin
        if (init_wr) begin
          init_state_nxt = CCI_INIT_START;
        end
      end
      CCI_INIT_START: begin
        init_state_nxt = CCI_INIT_BUSY;
      end
      CCI_INIT_BUSY: begin
        if (INIT_DONE) begin
          init_state_nxt = CCI_INIT_IDLE;
        end
      end
      default: begin
        init_state_nxt = CCI_INIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      init_state_r <= CCI_INIT_IDLE;
    end else begin
      init_state_r <= init_state_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      init_start_r <= 1'b0;
      init_busy_r  <= 1'b0;
    end else begin
      init_start_r <= (init_state_nxt == CCI_INIT_START);
      init_busy_r  <= (init_state_nxt != CCI_INIT_IDLE);
    end
  end

  assign RSP        = rsp_r;
  assign INIT_START = init_start_r;
  assign INIT_BUSY  = init_busy_r;

endmodule : cci_regs

/* File: sim/cci_regs_asserts.sv */
module cci_regs_chk
  import cci_pkg::*;
(
  input wire logic      CLOCK,
  input wire logic      RST_N,
  input wire cci_req_s  REQ,
  input wire cci_caps_s CAPS,
  input wire logic      INIT_DONE,
  input wire cci_rsp_s  RSP,
  input wire logic      INIT_START,
  input wire logic      INIT_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Helpers and assertions.
  // ********
  logic ok_r;
  logic rd;
  logic [11:0] ofs;
  assign ofs = REQ.addr[11:0];
  assign rd  = ok_r && REQ.valid && !REQ.write
               && REQ.addr[31:12] == CCI_BASE_PAGE;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) ok_r <= 1'b0;
    else ok_r <= 1'b1;
  end
  function automatic logic [31:0] cw(logic [7:0] f, logic [7:0] m);
    cw = CCI_ZERO_WORD;
    for (int i = 0; i < 8; i++) cw[31-i] = f[i] & m[i];
  endfunction : cw
  misalign_err_a: assert property (
    REQ.valid && REQ.addr[31:12] == CCI_BASE_PAGE && REQ.addr[1:0] != 2'h0
    |=> RSP.valid && RSP.code == CCI_RSP_TYPE_ERR)
    else $error("Misaligned address not refused.");
  addr_err_a: assert property (
    REQ.valid && REQ.addr[31:12] != CCI_BASE_PAGE && REQ.addr[1:0] == 2'h0
    |=> RSP.valid && RSP.code == CCI_RSP_ADDR_ERR)
    else $error("Foreign address not refused.");
  init_go_a: assert property (
    REQ.valid && REQ.write && REQ.addr == CCI_BASE_ADDR && REQ.wdata[31]
    && !INIT_BUSY |=> INIT_START && INIT_BUSY)
    else $error("Init write did not start init.");
  init_pulse_a: assert property (INIT_START |=> !INIT_START)
    else $error("Init start longer than one cycle.");
  busy_hold_a: assert property (
    INIT_BUSY && !INIT_DONE |=> INIT_BUSY)
    else $error("Busy fell before done.");
  fmt_word_a: assert property (
    rd && ofs == CCI_OFS_FMT
    |=> RSP.rdata == cw($past(CAPS.formats, 2), CCI_MASK_FMT))
    else $error("Format word wrong.");
  f0_mode_a: assert property (
    rd && ofs == CCI_OFS_F0M
    |=> RSP.rdata == cw($past(CAPS.f0_modes, 2), CCI_MASK_F0M))
    else $error("Format 0 mode word wrong.");
  f7_mode_a: assert property (
    rd && ofs == CCI_OFS_F7M
    |=> RSP.rdata == cw($past(CAPS.f7_modes, 2), CCI_MASK_FULL))
    else $error("Format 7 mode word wrong.");
  rate0_word_a: assert property (
    rd && ofs == CCI_OFS_F0R0
    |=> RSP.rdata == cw($past(CAPS.f0_rates[0], 2), CCI_MASK_F0R0))
    else $error("Mode 0 rate word wrong.");
  low_zero_a: assert property (RSP.valid |-> RSP.rdata[23:0] == 24'h0)
    else $error("Low bits not zero.");
endmodule : cci_regs_chk

/* File: sim/cci_core_model.sv */
module cci_core_model
  import cci_pkg::*;
#(
  parameter int DONE_DLY = 6
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic init_start,
  output cci_caps_s caps,
  output logic      init_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Capability flags and init completion.
  // ********
  int cnt_r;
  assign caps = {8'hFF, 8'hFF, 8'h5A, 8'hC3, 8'h3C, 40'h810FF096FF};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= 0;
      init_done <= 1'b0;
    end else begin
      init_done <= (cnt_r == 1);
      if (init_start) cnt_r <= DONE_DLY;
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
  end
endmodule : cci_core_model

/* File: sim/tb.sv */
`define CHK(g, w) begin check_count++; if ((g) !== (w)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, g, w); end end
module tb
  import cci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench.
  // ********
  logic        clock;
  logic        rst_n;
  logic        init_done;
  logic        init_start;
  logic        init_busy;
  cci_req_s    req;
  cci_caps_s   caps;
  cci_rsp_s    rsp;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [11:0] ofs [14];
  logic [7:0]  fl [14];
  logic [7:0]  mk [14];
  cci_regs u_cci_regs (.CLOCK(clock), .RST_N(rst_n), .REQ(req), .CAPS(caps),
    .INIT_DONE(init_done), .RSP(rsp), .INIT_START(init_start),
    .INIT_BUSY(init_busy));
  cci_core_model u_cci_core_model (.clock(clock), .rst_n(rst_n),
    .init_start(init_start), .caps(caps), .init_done(init_done));
  function automatic logic [31:0] xw(logic [7:0] f, logic [7:0] m);
    xw = CCI_ZERO_WORD;
    for (int i = 0; i < 8; i++) xw[31-i] = f[i] & m[i];
  endfunction : xw
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic quad(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input cci_rsp_e c,
                      input logic [31:0] x);
    @(posedge clock);
    req <= '{1'b1, w, a, d};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    `CHK(rsp.valid, 1'b1)
    `CHK(rsp.code, c)
    `CHK(rsp.rdata, x)
  endtask : quad
  task automatic rd(input logic [31:0] a, input cci_rsp_e c,
                    input logic [31:0] x);
    quad(1'b0, a, CCI_ZERO_WORD, c, x);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    quad(1'b1, a, d, CCI_RSP_COMPLETE, CCI_ZERO_WORD);
  endtask : wr
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    req   = '0;
    rst_n = 1'b0;
    ofs = '{CCI_OFS_FMT, CCI_OFS_F0M, CCI_OFS_F1M, CCI_OFS_F2M, CCI_OFS_RSV0,
      CCI_OFS_RSV1, CCI_OFS_RSV2, CCI_OFS_F6M, CCI_OFS_F7M, CCI_OFS_F0R0,
      CCI_OFS_F0R1, CCI_OFS_F0R2, CCI_OFS_F0R3, CCI_OFS_F0R4};
    mk = '{CCI_MASK_FMT, CCI_MASK_F0M, CCI_MASK_FULL, CCI_MASK_FULL,
      CCI_MASK_NONE, CCI_MASK_NONE, CCI_MASK_NONE, CCI_MASK_NONE,
      CCI_MASK_FULL, CCI_MASK_F0R0, CCI_MASK_FULL, CCI_MASK_FULL,
      CCI_MASK_FULL, CCI_MASK_FULL};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    fl = '{caps.formats, caps.f0_modes, caps.f1_modes, caps.f2_modes, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, caps.f7_modes, caps.f0_rates[0], caps.f0_rates[1],
      caps.f0_rates[2], caps.f0_rates[3], caps.f0_rates[4]};
    for (int i = 0; i < 14; i++) begin
      rd({CCI_BASE_PAGE, ofs[i]}, CCI_RSP_COMPLETE, xw(fl[i], mk[i]));
    end
    $display("Inquiry map test done.");
    wr({CCI_BASE_PAGE, CCI_OFS_FMT}, 32'hFFFFFFFF);
    rd({CCI_BASE_PAGE, CCI_OFS_FMT}, CCI_RSP_COMPLETE, xw(fl[0], mk[0]));
    $display("Read-only test done.");
    rd(32'hF0F01100, CCI_RSP_ADDR_ERR, CCI_ZERO_WORD);
    rd(32'hE0F00100, CCI_RSP_ADDR_ERR, CCI_ZERO_WORD);
    rd(32'hF0F00300, CCI_RSP_ADDR_ERR, CCI_ZERO_WORD);
    rd(32'hF0F00102, CCI_RSP_TYPE_ERR, CCI_ZERO_WORD);
    $display("Decode test done.");
    wr(CCI_BASE_ADDR, 32'h80000000);
    `CHK(init_start, 1'b1)
    `CHK(init_busy, 1'b1)
    wr(CCI_BASE_ADDR, 32'h80000000);
    for (int k = 0; k < 20 && init_busy; k++) @(posedge clock);
    #1;
    `CHK(init_busy, 1'b0)
    wr(CCI_BASE_ADDR, 32'h7FFFFFFF);
    `CHK(init_start, 1'b0)
    $display("Init test done.");
    give_verdict();
  end
endmodule : tb
bind cci_regs cci_regs_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .REQ(REQ),
  .CAPS(CAPS), .INIT_DONE(INIT_DONE), .RSP(RSP), .INIT_START(INIT_START),
  .INIT_BUSY(INIT_BUSY));
